// ===== rtl/esid_pkg.sv
package esid_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_INPUTS = 12;
  localparam int BASE_INPUTS = 4;
  localparam int PROG_W = 5;
  localparam int FN_W = 3;
  localparam int NUM_EVT = 8;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 10;                // Sampling tick period
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int EDGE_READ_MAX_MS = 200;      // Edge read latency bound
  localparam int SEL_READ_MAX_MS = 400;       // Selection read bound

  // ---------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_EVENT = 4'h8;
  localparam logic [3:0] ADDR_PROG = 4'hc;
  localparam int CTRL_FN5_LSB = 0;
  localparam int CTRL_FN6_LSB = 3;
  localparam int CTRL_FN7_LSB = 6;
  localparam int CTRL_OPT_BIT = 9;
  localparam logic [9:0] CTRL_RESET = 10'h000;
  localparam int STAT_SEL_LSB = 12;
  localparam int STAT_PROG_LSB = 17;
  localparam int STAT_EXT_BIT = 22;
  localparam logic [4:0] PROG_RESET = 5'h01;
  localparam logic [4:0] PROG_MIN = 5'h01;
  localparam logic [4:0] PROG_MAX = 5'h13;

  // Event bit positions
  localparam int EV_RUN = 0;
  localparam int EV_HOLD = 1;
  localparam int EV_RESET = 2;
  localparam int EV_ADV = 3;
  localparam int EV_FAST = 4;
  localparam int EV_PVST = 5;
  localparam int EV_AM = 6;
  localparam int EV_AT = 7;

  // Functions selectable for inputs five to seven
  typedef enum logic [2:0] {
    FN_NONE = 3'h0,
    FN_FAST = 3'h1,
    FN_PV_START = 3'h2,
    FN_AUTO_MAN = 3'h3,
    FN_AUTOTUNE = 3'h4,
    FN_SOAK_OR = 3'h5,
    FN_SOAK_AND = 3'h6,
    FN_REVERSE = 3'h7
  } esid_fn_e;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } esid_bus_e;
endpackage : esid_pkg

// ===== rtl/esid_smp_if.sv
`timescale 1ns/100ps
`default_nettype none
// Sampled contact inputs handed from the sampler to the decoder
interface esid_smp_if #(
  parameter int N = 12
);
  logic tick;
  logic [N-1:0] level;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport src (output tick, output level, output rise, output fall);
  modport dst (input tick, input level, input rise, input fall);
endinterface : esid_smp_if
`default_nettype wire

// ===== rtl/esid_sampler.sv
`timescale 1ns/100ps
`default_nettype none
module esid_sampler #(
  parameter int N = 12,
  parameter int TICK_CYCLES = 400000
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [N-1:0] pins,
  esid_smp_if.src smp
);
  // ---------------------------------------------------------------
  // Three-stage synchronisers
  // ---------------------------------------------------------------
  logic [N-1:0] s1_reg, s2_reg, s3_reg, stab_reg, stab_next;
  logic [N-1:0] samp_reg, samp_next, rise_reg, rise_next;
  logic [N-1:0] fall_reg, fall_next;
  logic [31:0] cnt_reg, cnt_next;
  logic tick_reg, tick_next;

  // A bit only moves once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_stab
      always_comb begin
        stab_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : stab_reg[g];
      end
    end
  endgenerate

  // Tick divider and sample comparison
  always_comb begin
    tick_next = (cnt_reg == 32'(TICK_CYCLES - 1));
    cnt_next = tick_next ? 32'h0 : cnt_reg + 32'h1;
    samp_next = tick_next ? stab_reg : samp_reg;
    rise_next = tick_next ? (stab_reg & ~samp_reg) : '0; // R26
    fall_next = tick_next ? (~stab_reg & samp_reg) : '0; // R26
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      stab_reg <= '0;
      samp_reg <= '0;
      rise_reg <= '0;
      fall_reg <= '0;
      cnt_reg <= 32'h0;
      tick_reg <= 1'b0;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stab_reg <= stab_next;
      samp_reg <= samp_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign smp.tick = tick_reg;
  assign smp.level = samp_reg;
  assign smp.rise = rise_reg;
  assign smp.fall = fall_reg;
endmodule : esid_sampler
`default_nettype wire

// ===== rtl/ext_switch_input_decoder.sv
// Contract
// R1: Twelve inputs; unfitted option leaves four
// R2: Inputs 1-4 edge commands; 8-12 program levels
// R3: Inputs 5-7 take setup-selected function
// R4: Fast/pv-start rise, toggles both edges, rest levels
// R5: Pv start only in program ready state
// R6: Without pv setpoint, start from segment
// R7: Soak-cancel OR: input or within width
// R8: Reversal input inverts configured control action
// R9: Contact selection only in program ready
// R10: Program number is sum of weights
// R11: Zero selection leaves console or host choice
// R12: Off-to-on read within 0.2 s
// R13: On-to-off read within 0.2 s
// R14: Program inputs read within 0.4 s
// R15: Far side holds selection 0.4 s before run
// R16: Far side holds selection 0.2 s after run
// R17: Far side keeps run off 0.2 s
// R18: Far side keeps run on 0.2 s
// R19: Selected program updates within 0.4 s
// R20: Run begins within 0.4 s of edge
// R21: Pv start obeys run input timing
// R22: Far side should add timing margin
// R23: Valid program numbers are one to nineteen
// R24: Active contact selection disables console keys
// R25: Weight sums above nineteen decode zero
// R26: Sample on tick, compare successive samples
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module ext_switch_input_decoder #(
  parameter int TICK_CYCLES = esid_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  // Contact pins, active high
  input wire logic [11:0] ext_contact_input,
  // State of the program engine
  input wire logic prog_mode,
  input wire logic ready_state,
  input wire logic pv_start_has_setpoint,
  input wire logic process_value_in_soak_width,
  input wire logic config_reverse_action,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Commands to the program engine
  output logic cmd_run,
  output logic cmd_hold,
  output logic cmd_reset,
  output logic cmd_segment_advance,
  output logic cmd_fast,
  output logic cmd_pv_start,
  output logic cmd_pv_start_from_segment,
  output logic cmd_auto_manual_toggle,
  output logic cmd_autotune_toggle,
  output logic soak_release,
  output logic reverse_action,
  output logic [4:0] program_number,
  output logic ext_select_active
);
  // ---------------------------------------------------------------
  // Sampling of the contact pins
  // ---------------------------------------------------------------
  esid_smp_if #(.N(esid_pkg::NUM_INPUTS)) smp ();

  // Sampling on a 10 ms tick keeps edge and level latency far below
  // the read bounds
  esid_sampler #(
    .N(esid_pkg::NUM_INPUTS),
    .TICK_CYCLES(TICK_CYCLES)
  ) u_sampler (
    .clk_sys(clk_sys),
    .reset(reset),
    .pins(ext_contact_input),
    .smp(smp)
  ); // R12 R13 R14 R26

  // ---------------------------------------------------------------
  // Decoding function
  // ---------------------------------------------------------------
  // Weighted sum of inputs 8..12; sums above nineteen give zero
  function automatic logic [4:0] esid_decode(input logic [4:0] w);
    logic [4:0] sum;
    sum = 5'h00;
    if (w[0]) sum = sum + 5'd1;
    if (w[1]) sum = sum + 5'd2;
    if (w[2]) sum = sum + 5'd4;
    if (w[3]) sum = sum + 5'd8;
    if (w[4]) sum = sum + 5'd10; // R10
    if (sum > esid_pkg::PROG_MAX) sum = 5'h00; // R25
    return sum;
  endfunction : esid_decode

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [9:0] ctrl_reg, ctrl_next;
  logic [esid_pkg::NUM_EVT-1:0] evt_reg, evt_next;
  logic [4:0] prog_reg, prog_next;
  logic [4:0] sel_reg, sel_next;
  esid_pkg::esid_bus_e bus_reg, bus_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wait_reg, wait_next;
  logic [8:0] cmd_reg, cmd_next;
  logic soak_reg, soak_next;
  logic rev_reg, rev_next;
  logic ext_reg, ext_next;

  // ---------------------------------------------------------------
  // Input masking and function routing
  // ---------------------------------------------------------------
  logic [11:0] lvl, rise, fall, fit_mask;
  logic [2:0] fn [3];
  logic fast_hit, pvst_hit, am_hit, at_hit;
  logic soak_or_on, soak_and_on, soak_or_sel, soak_and_sel;
  logic rev_on, prog_ready, pv_ok, run_rise;
  logic [4:0] dec_sel;

  // Unfitted option: only the first four contacts exist
  always_comb begin
    fit_mask = ctrl_reg[esid_pkg::CTRL_OPT_BIT] ? 12'hfff : 12'h00f; // R1
    lvl = smp.level & fit_mask;
    rise = smp.rise & fit_mask;
    fall = smp.fall & fit_mask;
    fn[0] = ctrl_reg[esid_pkg::CTRL_FN5_LSB +: esid_pkg::FN_W];
    fn[1] = ctrl_reg[esid_pkg::CTRL_FN6_LSB +: esid_pkg::FN_W];
    fn[2] = ctrl_reg[esid_pkg::CTRL_FN7_LSB +: esid_pkg::FN_W];
  end

  // Each of inputs 5..7 drives whichever function setup names
  always_comb begin
    fast_hit = 1'b0;
    pvst_hit = 1'b0;
    am_hit = 1'b0;
    at_hit = 1'b0;
    soak_or_on = 1'b0;
    soak_and_on = 1'b0;
    soak_or_sel = 1'b0;
    soak_and_sel = 1'b0;
    rev_on = 1'b0;
    for (int i = 0; i < 3; i++) begin // R3
      case (fn[i])
        esid_pkg::FN_FAST: begin
          fast_hit = fast_hit | rise[4+i]; // R4
        end
        esid_pkg::FN_PV_START: begin
          pvst_hit = pvst_hit | rise[4+i]; // R4
        end
        esid_pkg::FN_AUTO_MAN: begin
          am_hit = am_hit | rise[4+i] | fall[4+i]; // R4
        end
        esid_pkg::FN_AUTOTUNE: begin
          at_hit = at_hit | rise[4+i] | fall[4+i]; // R4
        end
        esid_pkg::FN_SOAK_OR: begin
          soak_or_sel = 1'b1;
          soak_or_on = soak_or_on | lvl[4+i];
        end
        esid_pkg::FN_SOAK_AND: begin
          soak_and_sel = 1'b1;
          soak_and_on = soak_and_on | lvl[4+i];
        end
        esid_pkg::FN_REVERSE: begin
          rev_on = rev_on | lvl[4+i];
        end
        default: begin
        end
      endcase
    end
  end

  // Program selection conditions
  always_comb begin
    dec_sel = esid_decode(lvl[11:7]);
    prog_ready = prog_mode & ready_state;
    pv_ok = pvst_hit & prog_ready; // R5 R21
    run_rise = rise[0];
  end

  // ---------------------------------------------------------------
  // Command and level outputs
  // ---------------------------------------------------------------
  // Command pulses last one clock; the engine starts at once (R20)
  always_comb begin
    cmd_next = '0;
    cmd_next[0] = run_rise; // R2 R20
    cmd_next[1] = rise[1]; // R2
    cmd_next[2] = rise[2]; // R2
    cmd_next[3] = rise[3]; // R2
    cmd_next[4] = fast_hit;
    cmd_next[5] = pv_ok; // R5
    cmd_next[6] = pv_ok & ~pv_start_has_setpoint; // R6
    cmd_next[7] = am_hit;
    cmd_next[8] = at_hit;
    // AND mode needs both the contact and the soak band
    if (soak_and_sel) begin
      soak_next = soak_and_on & process_value_in_soak_width;
    end else if (soak_or_sel) begin
      soak_next = soak_or_on | process_value_in_soak_width; // R7
    end else begin
      soak_next = process_value_in_soak_width;
    end
    rev_next = config_reverse_action ^ rev_on; // R8
    ext_next = (dec_sel != 5'h00); // R11
    sel_next = dec_sel; // R14
  end

  // ---------------------------------------------------------------
  // Selected program number
  // ---------------------------------------------------------------
  // Contact selection wins over console writes; zero hands back
  always_comb begin
    prog_next = prog_reg;
    if (prog_ready && ext_next && (smp.tick || run_rise)) begin // R9
      prog_next = dec_sel; // R19 R11
    end else if (bus_reg == esid_pkg::BUS_ACK && avs_write &&
                 avs_address == esid_pkg::ADDR_PROG && prog_ready &&
                 !ext_reg) begin // R24
      if (avs_writedata[4:0] >= esid_pkg::PROG_MIN &&
          avs_writedata[4:0] <= esid_pkg::PROG_MAX) begin // R23
        prog_next = avs_writedata[4:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------
  // One wait cycle per access: simple, and reads come from flops
  always_comb begin
    bus_next = bus_reg;
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    ctrl_next = ctrl_reg;
    case (bus_reg)
      esid_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_next = esid_pkg::BUS_ACK;
          wait_next = 1'b0;
          rdata_next = 32'h0;
          if (avs_read) begin
            if (avs_address == esid_pkg::ADDR_CTRL) begin
              rdata_next[9:0] = ctrl_reg;
            end else if (avs_address == esid_pkg::ADDR_STATUS) begin
              rdata_next[11:0] = lvl;
              rdata_next[esid_pkg::STAT_SEL_LSB +: 5] = sel_reg;
              rdata_next[esid_pkg::STAT_PROG_LSB +: 5] = prog_reg;
              rdata_next[esid_pkg::STAT_EXT_BIT] = ext_reg;
            end else if (avs_address == esid_pkg::ADDR_EVENT) begin
              rdata_next[esid_pkg::NUM_EVT-1:0] = evt_reg;
            end else if (avs_address == esid_pkg::ADDR_PROG) begin
              rdata_next[4:0] = prog_reg;
            end
          end
        end
      end
      esid_pkg::BUS_ACK: begin
        bus_next = esid_pkg::BUS_IDLE;
        if (avs_write && avs_address == esid_pkg::ADDR_CTRL) begin
          ctrl_next = avs_writedata[9:0];
        end
      end
      default: begin
        bus_next = esid_pkg::BUS_IDLE;
      end
    endcase
  end

  // Sticky event flags, write one to clear; a new event beats clear
  always_comb begin
    evt_next = evt_reg;
    if (bus_reg == esid_pkg::BUS_ACK && avs_write &&
        avs_address == esid_pkg::ADDR_EVENT) begin
      evt_next = evt_reg & ~avs_writedata[esid_pkg::NUM_EVT-1:0];
    end
    evt_next[esid_pkg::EV_RUN] = evt_next[esid_pkg::EV_RUN] | cmd_next[0];
    evt_next[esid_pkg::EV_HOLD] = evt_next[esid_pkg::EV_HOLD] | cmd_next[1];
    evt_next[esid_pkg::EV_RESET] = evt_next[esid_pkg::EV_RESET] | cmd_next[2];
    evt_next[esid_pkg::EV_ADV] = evt_next[esid_pkg::EV_ADV] | cmd_next[3];
    evt_next[esid_pkg::EV_FAST] = evt_next[esid_pkg::EV_FAST] | cmd_next[4];
    evt_next[esid_pkg::EV_PVST] = evt_next[esid_pkg::EV_PVST] | cmd_next[5];
    evt_next[esid_pkg::EV_AM] = evt_next[esid_pkg::EV_AM] | cmd_next[7];
    evt_next[esid_pkg::EV_AT] = evt_next[esid_pkg::EV_AT] | cmd_next[8];
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_reg <= esid_pkg::CTRL_RESET;
      evt_reg <= '0;
      prog_reg <= esid_pkg::PROG_RESET;
      sel_reg <= 5'h00;
      bus_reg <= esid_pkg::BUS_IDLE;
      rdata_reg <= 32'h0;
      wait_reg <= 1'b1;
      cmd_reg <= '0;
      soak_reg <= 1'b0;
      rev_reg <= 1'b0;
      ext_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      evt_reg <= evt_next;
      prog_reg <= prog_next;
      sel_reg <= sel_next;
      bus_reg <= bus_next;
      rdata_reg <= rdata_next;
      wait_reg <= wait_next;
      cmd_reg <= cmd_next;
      soak_reg <= soak_next;
      rev_reg <= rev_next;
      ext_reg <= ext_next;
    end
  end

  // ---------------------------------------------------------------
  // Output wiring, all straight from flops
  // ---------------------------------------------------------------
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign cmd_run = cmd_reg[0];
  assign cmd_hold = cmd_reg[1];
  assign cmd_reset = cmd_reg[2];
  assign cmd_segment_advance = cmd_reg[3];
  assign cmd_fast = cmd_reg[4];
  assign cmd_pv_start = cmd_reg[5];
  assign cmd_pv_start_from_segment = cmd_reg[6];
  assign cmd_auto_manual_toggle = cmd_reg[7];
  assign cmd_autotune_toggle = cmd_reg[8];
  assign soak_release = soak_reg;
  assign reverse_action = rev_reg;
  assign program_number = prog_reg;
  assign ext_select_active = ext_reg;
endmodule : ext_switch_input_decoder
`default_nettype wire

// ===== sim/esid_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// --------------------------------------------------------------
// Port-level checker for the contact input decoder
// --------------------------------------------------------------
module esid_asserts #(
  parameter int TICK_CYCLES = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [11:0] ext_contact_input,
  input wire logic prog_mode,
  input wire logic ready_state,
  input wire logic pv_start_has_setpoint,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic cmd_run,
  input wire logic cmd_segment_advance,
  input wire logic cmd_pv_start,
  input wire logic cmd_pv_start_from_segment,
  input wire logic [4:0] program_number
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Two sim ticks plus sync stages; far tighter than the 0.2 s bound
  localparam int LAT = 40;
  sequence s_take;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_bus_answer: assert property (s_take |=> s_answer)
    else $error("bus answer not one cycle after take");
  a_bus_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  a_run_rise: assert property ($rose(ext_contact_input[0]) |-> ##[1:LAT] cmd_run)
    else $error("run command late or missing");
  a_adv_rise: assert property ($rose(ext_contact_input[3]) |-> ##[1:LAT] cmd_segment_advance)
    else $error("advance command late or missing");
  a_run_on_pin: assert property (cmd_run |-> ext_contact_input[0])
    else $error("run command without pin on");
  a_run_one_cycle: assert property (cmd_run |=> !cmd_run)
    else $error("run command longer than one cycle");
  a_pv_gate: assert property (cmd_pv_start |-> $past(prog_mode && ready_state))
    else $error("pv start outside program ready");
  a_pv_segment: assert property ((cmd_pv_start || cmd_pv_start_from_segment) |->
    cmd_pv_start && (cmd_pv_start_from_segment != $past(pv_start_has_setpoint)))
    else $error("segment start flag wrong");
  a_prog_range: assert property (program_number >= 5'h01 && program_number <= 5'h13)
    else $error("program number out of range");
  a_prog_gate: assert property ($changed(program_number) |->
    $past(prog_mode && ready_state) || $past(reset))
    else $error("program changed outside program ready");
endmodule : esid_asserts
bind ext_switch_input_decoder esid_asserts #(.TICK_CYCLES(TICK_CYCLES)) esid_asserts_i (
  .clk_sys, .reset, .ext_contact_input, .prog_mode, .ready_state,
  .pv_start_has_setpoint, .avs_read, .avs_write, .avs_waitrequest, .cmd_run,
  .cmd_segment_advance, .cmd_pv_start, .cmd_pv_start_from_segment,
  .program_number);
`default_nettype wire

// ===== sim/esid_contact_model.sv
`timescale 1ns/100ps
`default_nettype none
// --------------------------------------------------------------
// Switch contacts driven by a sequencer
// --------------------------------------------------------------
module esid_contact_model #(
  parameter int TICK_CYCLES = 16
) (
  input wire logic clk_sys,
  output logic [11:0] ext_contact_input
);
  // 0.2 s and 0.4 s in 10 ms ticks, one tick of margin added
  localparam int T200 = 21 * TICK_CYCLES;
  localparam int T400 = 41 * TICK_CYCLES;
  initial ext_contact_input = 12'h000;
  task automatic hold_for(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : hold_for
  // On then off, each phase held its minimum; selection untouched
  task automatic pulse(input int idx);
    @(posedge clk_sys);
    ext_contact_input[idx] <= 1'b1;
    hold_for(T200);
    ext_contact_input[idx] <= 1'b0;
    hold_for(T200);
  endtask : pulse
  task automatic level(input int idx, input logic v);
    @(posedge clk_sys);
    ext_contact_input[idx] <= v;
    hold_for(T200);
  endtask : level
  // Selection settles well before any run edge follows
  task automatic select(input logic [4:0] w);
    @(posedge clk_sys);
    ext_contact_input[11:7] <= w;
    hold_for(T400);
  endtask : select
endmodule : esid_contact_model
`default_nettype wire

// ===== sim/ext_switch_input_decoder_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ext_switch_input_decoder_tb_top;
  localparam int TK = 16;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [11:0] ext_contact_input;
  logic prog_mode = 1'b0;
  logic ready_state = 1'b0;
  logic pv_start_has_setpoint = 1'b0;
  logic process_value_in_soak_width = 1'b0;
  logic config_reverse_action = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [8:0] cmd; // seg, at, am, pv, fast, adv, reset, hold, run
  logic soak_release;
  logic reverse_action;
  logic ext_select_active;
  logic [4:0] program_number;
  logic [31:0] rd;
  logic [4:0] codes [7] = '{5'h01, 5'h10, 5'h0a, 5'h19, 5'h1a, 5'h03, 5'h00};
  int n_fail = 0;
  int total_checks = 0;
  int cnt [9] = '{default: 0};
  int cycles = 0;
  int base;
  int e;
  int exp_prog = 1;

  ext_switch_input_decoder #(.TICK_CYCLES(TK)) ext_switch_input_decoder_i (
    .clk_sys(clk_sys), .reset(reset), .ext_contact_input(ext_contact_input),
    .prog_mode(prog_mode), .ready_state(ready_state),
    .pv_start_has_setpoint(pv_start_has_setpoint),
    .process_value_in_soak_width(process_value_in_soak_width),
    .config_reverse_action(config_reverse_action), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cmd_run(cmd[0]), .cmd_hold(cmd[1]), .cmd_reset(cmd[2]),
    .cmd_segment_advance(cmd[3]), .cmd_fast(cmd[4]), .cmd_pv_start(cmd[5]),
    .cmd_pv_start_from_segment(cmd[8]), .cmd_auto_manual_toggle(cmd[6]),
    .cmd_autotune_toggle(cmd[7]), .soak_release(soak_release),
    .reverse_action(reverse_action), .program_number(program_number),
    .ext_select_active(ext_select_active));
  esid_contact_model #(.TICK_CYCLES(TK)) esid_contact_model_i (
    .clk_sys(clk_sys), .ext_contact_input(ext_contact_input));

  always #12.5 clk_sys = ~clk_sys;
  // Count command pulses; a stuck bench is cut off well past the plan
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    foreach (cnt[k]) cnt[k] <= cnt[k] + int'(cmd[k] === 1'b1);
    if (cycles == 40000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Avalon request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    check("program at reset", 32'(program_number), 32'h1);
    esid_contact_model_i.select(5'h03);
    bus(1'b0, esid_pkg::ADDR_STATUS, 32'h0);
    check("status without option", rd, 32'h0002_0000);
    bus(1'b0, esid_pkg::ADDR_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    check("unmapped read", rd, 32'h0);
    esid_contact_model_i.select(5'h00);
    bus(1'b1, esid_pkg::ADDR_CTRL, 32'h3d1);
    bus(1'b0, esid_pkg::ADDR_CTRL, 32'h0);
    check("ctrl readback", rd, 32'h3d1);
    $display("test done: setup");
    // Fixed edge inputs, then fast and pv start on five and six
    prog_mode <= 1'b1;
    ready_state <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      base = cnt[i];
      esid_contact_model_i.pulse(i);
      check("command count", 32'(cnt[i] - base), 32'h1);
      bus(1'b0, esid_pkg::ADDR_EVENT, 32'h0);
      check("event bits", rd, 32'h1 << i);
      bus(1'b1, esid_pkg::ADDR_EVENT, 32'hff);
    end
    check("segment start", 32'(cnt[8]), 32'h1);
    prog_mode <= 1'b0;
    base = cnt[5];
    esid_contact_model_i.pulse(5);
    ready_state <= 1'b0;
    prog_mode <= 1'b1;
    esid_contact_model_i.pulse(5);
    check("pv start refused", 32'(cnt[5] - base), 32'h0);
    ready_state <= 1'b1;
    pv_start_has_setpoint <= 1'b1;
    esid_contact_model_i.pulse(5);
    check("pv start taken", 32'(cnt[5] - base), 32'h1);
    check("no segment start", 32'(cnt[8]), 32'h1);
    $display("test done: edge commands");
    // Reversal follows contact and configured action together
    for (int v = 0; v < 2; v++) begin
      config_reverse_action <= v[0];
      esid_contact_model_i.level(6, 1'b1);
      check("reverse on", 32'(reverse_action), 32'(!v[0]));
      esid_contact_model_i.level(6, 1'b0);
      check("reverse off", 32'(reverse_action), 32'(v[0]));
    end
    // Both-edge toggles: each edge counts once
    for (int c = 3; c < 5; c++) begin
      bus(1'b1, esid_pkg::ADDR_CTRL, 32'h200 | (c << 6));
      base = cnt[c + 3];
      esid_contact_model_i.level(6, 1'b1);
      esid_contact_model_i.level(6, 1'b0);
      check("toggle count", 32'(cnt[c + 3] - base), 32'h2);
    end
    // Soak OR releases on band alone, soak AND does not
    for (int c = 5; c < 7; c++) begin
      bus(1'b1, esid_pkg::ADDR_CTRL, 32'h200 | (c << 6));
      process_value_in_soak_width <= 1'b0;
      esid_contact_model_i.level(6, 1'b1);
      check("soak by contact", 32'(soak_release), 32'(c == 5));
      process_value_in_soak_width <= 1'b1;
      esid_contact_model_i.level(6, 1'b1);
      check("soak by both", 32'(soak_release), 32'h1);
      esid_contact_model_i.level(6, 1'b0);
      check("soak by band", 32'(soak_release), 32'(c == 5));
    end
    $display("test done: selectable functions");
    // Weighted selection, double codes and an over-range sum
    foreach (codes[j]) begin
      e = codes[j][0] + 2 * codes[j][1] + 4 * codes[j][2] + 8 * codes[j][3]
          + 10 * codes[j][4];
      if (e > 19) e = 0;
      if (e != 0) exp_prog = e;
      esid_contact_model_i.select(codes[j]);
      check("select active", 32'(ext_select_active), 32'(e != 0));
      check("program", 32'(program_number), exp_prog);
      bus(1'b0, esid_pkg::ADDR_STATUS, 32'h0);
      check("decoded", 32'(rd[16:12]), e);
    end
    bus(1'b1, esid_pkg::ADDR_PROG, 32'h7);
    bus(1'b0, esid_pkg::ADDR_PROG, 32'h0);
    check("host program", rd, 32'h7);
    esid_contact_model_i.select(5'h01);
    bus(1'b1, esid_pkg::ADDR_PROG, 32'h9);
    bus(1'b0, esid_pkg::ADDR_PROG, 32'h0);
    check("host locked out", rd, 32'h1);
    ready_state <= 1'b0;
    esid_contact_model_i.select(5'h02);
    check("not ready", 32'(program_number), 32'h1);
    $display("test done: program selection");
    end_sim();
  end
endmodule : ext_switch_input_decoder_tb_top
`default_nettype wire
